// ===== secondary_irq_pkg.sv
// Constants, field layouts and carrier types for the secondary interrupt block
// What this block does
// - Status bits 0-3 catch both edges of shifter A and level A; drive line 60.
// - Status bits 4-7 catch both edges of shifter B and level B; drive line 59.
// - Status bit 8 follows receive buffer A loaded; drives line 58.
// - Status bit 9 follows transmit buffer A vacant; drives line 58.
// - Status bits 10 and 11 follow buffer pair B; drive line 57.
// - Software requests 0 to 3 drive lines 47 to 50 in order.
// - Writing one to control bits 7-4 raises the matching software request.
// - Writing one to control bits 3-0 drops the matching software request.
// - Both control nibbles read back the same four software request flags.
// - A pending line raises an exception only if its level exceeds the core mask.
// - Selector fields 27:22 and 21:16 each pick one of 64 lines.
// - Each probe pin continuously shows the pending state of its selected line.
// - Byte-lane writes to the low byte leave the probe selectors untouched.
// - Lines 0 to 17 carry the audio unit conditions, tick on line 8.
// - Lines 13 and 7 are the OR of three user/Q errors of receivers A and B.
// - The supplied vector is the base vector plus the line number.
package secondary_irq_pkg;

    // Register byte addresses
    localparam logic [11:0] SW_CTRL_ADDR     = 12'h198;
    localparam logic [11:0] CARD_STATUS_ADDR = 12'h1A0;
    localparam logic [11:0] CARD_ENABLE_ADDR = 12'h1A4;
    localparam logic [11:0] CARD_CLEAR_ADDR  = 12'h1A8;
    localparam logic [11:0] EVT_STATUS_ADDR  = 12'h1AC;
    localparam logic [11:0] EVT_MASK_ADDR    = 12'h1B0;
    localparam logic [11:0] BASE_VEC_ADDR    = 12'h1B4;
    localparam logic [11:0] LEVEL_BASE_ADDR  = 12'h1C0;
    localparam logic [11:0] LEVEL_LAST_ADDR  = 12'h1DC;

    // Control register fields
    localparam int SW_CLR_LSB  = 0;
    localparam int SW_SET_LSB  = 4;
    localparam int PROBE_A_LSB = 16;
    localparam int PROBE_B_LSB = 22;

    // Secondary line numbers owned here
    localparam int SW_LINE_LSB   = 47;
    localparam int CARD_LINE_B2  = 57;
    localparam int CARD_LINE_A2  = 58;
    localparam int CARD_LINE_B1  = 59;
    localparam int CARD_LINE_A1  = 60;
    localparam int AUDIO_LINE_HI = 17;

    // Lines driven from outside this block; owned lines are masked off
    localparam logic [63:0] EXT_LINE_MASK = 64'hE1F8_7FFF_FFFC_0000;

    // Values after reset
    localparam logic [3:0]  SW_RESET      = 4'h0;
    localparam logic [5:0]  PROBE_RESET   = 6'h00;
    localparam logic [11:0] CARD_EN_RESET = 12'h000;
    localparam logic [7:0]  BASE_RESET    = 8'h40;
    localparam logic [2:0]  LEVEL_RESET   = 3'h0;

    // Event status bits
    localparam int EVT_EXC_RISE  = 0;
    localparam int EVT_CARD_RISE = 1;
    localparam int EVT_WIDTH     = 2;

    // Audio unit conditions for lines 0 to 17
    typedef struct packed {
        logic [3:0] rxBStatus;   // Lines 17..14
        logic [2:0] uqErrRxA;    // ORed onto line 13
        logic [4:0] midFlags;    // Lines 12..8, tick on line 8
        logic [2:0] uqErrRxB;    // ORed onto line 7
        logic [6:0] lowFlags;    // Lines 6..0
    } audio_src_type;

    // Media-card request signals
    typedef struct packed {
        logic shifterA;
        logic levelA;
        logic shifterB;
        logic levelB;
        logic rxBufferALoaded;
        logic txBufferAVacant;
        logic rxBufferBLoaded;
        logic txBufferBVacant;
    } card_src_type;

endpackage : secondary_irq_pkg

// ===== secondary_irq_softint_monitor.sv
// Secondary interrupt sources, software requests, latency probes and APB slave
module secondary_irq_softint_monitor #(
    parameter int LINES = 64
) (
    // Clock and reset
    input  wire logic                           core_clk,
    input  wire logic                           rst,
    // APB slave
    input  wire logic                           psel,
    input  wire logic                           penable,
    input  wire logic                           pwrite,
    input  wire logic [11:0]                    paddr,
    input  wire logic [31:0]                    pwdata,
    input  wire logic [3:0]                     pstrb,
    output logic      [31:0]                    prdata,
    output logic                                pready,
    output logic                                pslverr,
    // Request sources
    input  wire secondary_irq_pkg::audio_src_type audioSrc,
    input  wire secondary_irq_pkg::card_src_type  cardSrc,
    input  wire logic [LINES-1:0]               extLines,
    // Core side
    input  wire logic [2:0]                     coreMask,
    output logic                                excReq,
    output logic      [7:0]                     excVector,
    output logic      [LINES-1:0]               secLines,
    // Probe pins and block interrupt
    output logic                                latency_probe_pin_a,
    output logic                                latency_probe_pin_b,
    output logic                                irqOut
);

    // Register state
    logic [3:0]  swReq_r;
    logic [5:0]  probeSelA_r;
    logic [5:0]  probeSelB_r;
    logic [7:0]  cardFlags_r;
    logic [11:0] cardEnable_r;
    logic [secondary_irq_pkg::EVT_WIDTH-1:0] evtStatus_r;
    logic [secondary_irq_pkg::EVT_WIDTH-1:0] evtMask_r;
    logic [7:0]  baseVec_r;
    logic [2:0]  levelTable_r [LINES];
    logic [3:0]  edgePrev_r;
    logic        cardAnyPrev_r;
    logic        excPrev_r;
    logic        ack_r;
    logic [31:0] prdata_r;
    logic        probeA_r;
    logic        probeB_r;
    logic        excReq_r;
    logic [7:0]  excVector_r;

    // APB decode; one wait state so read data comes from a flop
    wire        accessPhase = psel & penable;
    wire        wrEn        = accessPhase & pwrite & ack_r;
    wire        selCtrl     = (paddr == secondary_irq_pkg::SW_CTRL_ADDR);
    wire        selCardSt   = (paddr == secondary_irq_pkg::CARD_STATUS_ADDR);
    wire        selCardEn   = (paddr == secondary_irq_pkg::CARD_ENABLE_ADDR);
    wire        selCardClr  = (paddr == secondary_irq_pkg::CARD_CLEAR_ADDR);
    wire        selEvtSt    = (paddr == secondary_irq_pkg::EVT_STATUS_ADDR);
    wire        selEvtMask  = (paddr == secondary_irq_pkg::EVT_MASK_ADDR);
    wire        selBase     = (paddr == secondary_irq_pkg::BASE_VEC_ADDR);
    wire        selLevel    = (paddr >= secondary_irq_pkg::LEVEL_BASE_ADDR) &&
                              (paddr <= secondary_irq_pkg::LEVEL_LAST_ADDR) &&
                              (paddr[1:0] == 2'h0);
    wire [2:0]  levelRow    = paddr[4:2];
    wire        mapped      = selCtrl | selCardSt | selCardEn | selCardClr | selEvtSt |
                              selEvtMask | selBase | selLevel;
    wire [31:0] laneMask    = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
    wire [31:0] wBits       = pwdata & laneMask;

    assign pready  = ack_r;
    assign pslverr = ack_r & ~mapped;
    assign prdata  = prdata_r;

    // Media-card edge capture: fall and rise per signal
    wire [3:0] edgeNow  = {cardSrc.levelB, cardSrc.shifterB, cardSrc.levelA, cardSrc.shifterA};
    wire [3:0] edgeRise = edgeNow & ~edgePrev_r;
    wire [3:0] edgeFall = ~edgeNow & edgePrev_r;
    wire [7:0] flagSet  = {edgeRise[3], edgeFall[3], edgeRise[2], edgeFall[2],
                           edgeRise[1], edgeFall[1], edgeRise[0], edgeFall[0]};
    wire [7:0] flagClr  = (wrEn & selCardClr) ? wBits[7:0] : 8'h00;
    // A new edge beats a simultaneous clear so no event is lost
    wire [7:0] cardFlags_nxt = (cardFlags_r & ~flagClr) | flagSet;

    // Buffer bits are live levels; the buffer drops them on read or write
    wire [3:0] bufferBits = {cardSrc.txBufferBVacant, cardSrc.rxBufferBLoaded,
                             cardSrc.txBufferAVacant, cardSrc.rxBufferALoaded};
    wire [11:0] cardStatus = {bufferBits, cardFlags_r};
    wire [11:0] cardActive = cardStatus & cardEnable_r;

    // Audio lines with the two OR-ed user/Q error lines
    wire [17:0] audioLines = {audioSrc.rxBStatus, |audioSrc.uqErrRxA, audioSrc.midFlags,
                              |audioSrc.uqErrRxB, audioSrc.lowFlags};

    // Secondary line vector
    logic [LINES-1:0] ownLines;
    always_comb begin
        ownLines = '0;
        ownLines[secondary_irq_pkg::AUDIO_LINE_HI:0] = audioLines;
        ownLines[secondary_irq_pkg::SW_LINE_LSB +: 4] = swReq_r;
        ownLines[secondary_irq_pkg::CARD_LINE_A1] = |cardActive[3:0];
        ownLines[secondary_irq_pkg::CARD_LINE_B1] = |cardActive[7:4];
        ownLines[secondary_irq_pkg::CARD_LINE_A2] = |cardActive[9:8];
        ownLines[secondary_irq_pkg::CARD_LINE_B2] = |cardActive[11:10];
    end
    assign secLines = ownLines | (extLines & secondary_irq_pkg::EXT_LINE_MASK);

    // Software request update: clear then set, so a set wins on a same-word write
    wire        ctrlLow  = wrEn & selCtrl & pstrb[0];
    wire [3:0]  swRaise  = ctrlLow ? pwdata[secondary_irq_pkg::SW_SET_LSB +: 4] : 4'h0;
    wire [3:0]  swDrop   = ctrlLow ? pwdata[secondary_irq_pkg::SW_CLR_LSB +: 4] : 4'h0;
    wire [3:0]  swReq_nxt = (swReq_r & ~swDrop) | swRaise;

    // Selector fields follow only the byte lanes that are written
    wire [31:0] ctrlOld  = {4'h0, probeSelB_r, probeSelA_r, 16'h0000};
    wire [31:0] ctrlNew  = (ctrlOld & ~laneMask) | wBits;
    wire [5:0]  probeSelA_nxt = (wrEn & selCtrl) ? ctrlNew[secondary_irq_pkg::PROBE_A_LSB +: 6]
                                                : probeSelA_r;
    wire [5:0]  probeSelB_nxt = (wrEn & selCtrl) ? ctrlNew[secondary_irq_pkg::PROBE_B_LSB +: 6]
                                                : probeSelB_r;

    // Highest level pending line; ties go to the lower line number
    logic [2:0] bestLevel;
    logic [5:0] bestLine;
    always_comb begin
        bestLevel = 3'h0;
        bestLine  = 6'h00;
        for (int i = 0; i < LINES; i++) begin
            if (secLines[i] && (levelTable_r[i] > bestLevel)) begin
                bestLevel = levelTable_r[i];
                bestLine  = i[5:0];
            end
        end
    end
    wire       excReq_nxt    = (bestLevel > coreMask);
    wire [7:0] excVector_nxt = baseVec_r + {2'b00, bestLine};

    // Block event flags, set beats the write-one clear
    wire cardAny = |cardActive;
    wire [secondary_irq_pkg::EVT_WIDTH-1:0] evtSet = {cardAny & ~cardAnyPrev_r,
                                                      excReq_r & ~excPrev_r};
    wire [secondary_irq_pkg::EVT_WIDTH-1:0] evtClr =
        (wrEn & selEvtSt) ? wBits[secondary_irq_pkg::EVT_WIDTH-1:0] : '0;
    wire [secondary_irq_pkg::EVT_WIDTH-1:0] evtStatus_nxt = (evtStatus_r & ~evtClr) | evtSet;
    assign irqOut = |(evtStatus_r & evtMask_r);

    // Read mux; both control nibbles mirror the request flags
    logic [31:0] rdMux;
    always_comb begin
        rdMux = 32'h0000_0000;
        if (selCtrl) begin
            rdMux = {4'h0, probeSelB_r, probeSelA_r, 8'h00, swReq_r, swReq_r};
        end else if (selCardSt) begin
            rdMux = {20'h00000, cardStatus};
        end else if (selCardEn) begin
            rdMux = {20'h00000, cardEnable_r};
        end else if (selEvtSt) begin
            rdMux = {30'h0, evtStatus_r};
        end else if (selEvtMask) begin
            rdMux = {30'h0, evtMask_r};
        end else if (selBase) begin
            rdMux = {24'h000000, baseVec_r};
        end else if (selLevel) begin
            for (int k = 0; k < 8; k++) begin
                rdMux[4*k +: 3] = levelTable_r[{levelRow, k[2:0]}];
            end
        end
    end

    // Bus handshake and read data
    always_ff @(posedge core_clk) begin
        if (rst) begin
            ack_r    <= 1'b0;
            prdata_r <= 32'h0000_0000;
        end else begin
            ack_r    <= accessPhase & ~ack_r;
            prdata_r <= (accessPhase & ~ack_r) ? rdMux : prdata_r;
        end
    end

    // Control and status registers
    always_ff @(posedge core_clk) begin
        if (rst) begin
            swReq_r       <= secondary_irq_pkg::SW_RESET;
            probeSelA_r   <= secondary_irq_pkg::PROBE_RESET;
            probeSelB_r   <= secondary_irq_pkg::PROBE_RESET;
            cardFlags_r   <= 8'h00;
            cardEnable_r  <= secondary_irq_pkg::CARD_EN_RESET;
            evtStatus_r   <= '0;
            evtMask_r     <= '0;
            baseVec_r     <= secondary_irq_pkg::BASE_RESET;
            edgePrev_r    <= 4'h0;
            cardAnyPrev_r <= 1'b0;
            excPrev_r     <= 1'b0;
        end else begin
            swReq_r       <= swReq_nxt;
            probeSelA_r   <= probeSelA_nxt;
            probeSelB_r   <= probeSelB_nxt;
            cardFlags_r   <= cardFlags_nxt;
            cardEnable_r  <= (wrEn & selCardEn) ? wBits[11:0] | (cardEnable_r & ~laneMask[11:0])
                                                : cardEnable_r;
            evtStatus_r   <= evtStatus_nxt;
            evtMask_r     <= (wrEn & selEvtMask & pstrb[0]) ? pwdata[1:0] : evtMask_r;
            baseVec_r     <= (wrEn & selBase & pstrb[0]) ? pwdata[7:0] : baseVec_r;
            edgePrev_r    <= edgeNow;
            cardAnyPrev_r <= cardAny;
            excPrev_r     <= excReq_r;
        end
    end

    // Level table, eight lines per word, one nibble each
    always_ff @(posedge core_clk) begin
        for (int j = 0; j < LINES; j++) begin
            if (rst) begin
                levelTable_r[j] <= secondary_irq_pkg::LEVEL_RESET;
            end else if (wrEn && selLevel && (levelRow == j[5:3]) && pstrb[j[2:1]]) begin
                levelTable_r[j] <= pwdata[4*j[2:0] +: 3];
            end
        end
    end

    // Probe pins and exception outputs, registered to keep pins glitch free
    always_ff @(posedge core_clk) begin
        if (rst) begin
            probeA_r    <= 1'b0;
            probeB_r    <= 1'b0;
            excReq_r    <= 1'b0;
            excVector_r <= 8'h00;
        end else begin
            probeA_r    <= secLines[probeSelA_r];
            probeB_r    <= secLines[probeSelB_r];
            excReq_r    <= excReq_nxt;
            excVector_r <= excVector_nxt;
        end
    end
    assign latency_probe_pin_a = probeA_r;
    assign latency_probe_pin_b = probeB_r;
    assign excReq              = excReq_r;
    assign excVector           = excVector_r;

    // Checks
    a_flag_rise_latch: assert property (@(posedge core_clk) disable iff (rst)
        edgeRise[0] |=> cardFlags_r[1]) else $error("rise of shifter A not latched");
    a_flag_fall_latch: assert property (@(posedge core_clk) disable iff (rst)
        edgeFall[3] |=> cardFlags_r[6]) else $error("fall of level B not latched");
    a_flag_sticky: assert property (@(posedge core_clk) disable iff (rst)
        cardFlags_r[0] && !(wrEn && selCardClr && wBits[0]) |=> cardFlags_r[0])
        else $error("card flag lost without clear");
    a_buffer_line: assert property (@(posedge core_clk) disable iff (rst)
        (cardSrc.rxBufferALoaded && cardEnable_r[8]) |-> secLines[58])
        else $error("line 58 missing");
    a_tx_line: assert property (@(posedge core_clk) disable iff (rst)
        (cardSrc.txBufferBVacant && cardEnable_r[11]) |-> secLines[57])
        else $error("line 57 missing");
    a_card_enable: assert property (@(posedge core_clk) disable iff (rst)
        (cardEnable_r[3:0] == 4'h0) |-> !secLines[60]) else $error("line 60 unmasked");
    a_sw_raise: assert property (@(posedge core_clk) disable iff (rst)
        (ctrlLow && pwdata[7]) |=> secLines[50]) else $error("request 3 not raised");
    a_sw_drop: assert property (@(posedge core_clk) disable iff (rst)
        (ctrlLow && pwdata[0] && !pwdata[4]) |=> !secLines[47])
        else $error("request 0 not dropped");
    a_sw_hold: assert property (@(posedge core_clk) disable iff (rst)
        !ctrlLow |=> $stable(swReq_r)) else $error("request changed without write");
    a_mirror_read: assert property (@(posedge core_clk) disable iff (rst)
        (ack_r && selCtrl && !pwrite) |-> prdata[7:4] == prdata[3:0])
        else $error("nibbles differ");
    a_lane_keep: assert property (@(posedge core_clk) disable iff (rst)
        (wrEn && selCtrl && pstrb[3:2] == 2'b00) |=> $stable(probeSelA_r) && $stable(probeSelB_r))
        else $error("selector changed by low byte write");
    a_probe_follow: assert property (@(posedge core_clk) disable iff (rst)
        $stable(probeSelA_r) |=> latency_probe_pin_a == $past(secLines[probeSelA_r]))
        else $error("probe A wrong");
    a_uq_or: assert property (@(posedge core_clk) disable iff (rst)
        secLines[13] == |audioSrc.uqErrRxA) else $error("line 13 wrong");
    a_exc_mask: assert property (@(posedge core_clk) disable iff (rst)
        excReq_r |-> $past(bestLevel) > $past(coreMask)) else $error("exception below mask");
    a_vector_sum: assert property (@(posedge core_clk) disable iff (rst)
        excReq_r |-> excVector_r == $past(baseVec_r) + {2'b00, $past(bestLine)})
        else $error("vector wrong");
    // Bus timing: exactly one wait state before the answer
    a_apb_wait: assert property (@(posedge core_clk) disable iff (rst)
        (accessPhase && !ack_r) |=> pready) else $error("no answer");

    c_card_event: cover property (@(posedge core_clk) disable iff (rst) evtSet[1]);
    c_exc_taken:  cover property (@(posedge core_clk) disable iff (rst) excReq_r && irqOut);
    // Writes are at least one bus transfer apart, so a gap is needed between them
    c_sw_set_clr: cover property (@(posedge core_clk) disable iff (rst) ctrlLow ##[2:20] ctrlLow);
    c_probe_high: cover property (@(posedge core_clk) disable iff (rst) latency_probe_pin_b);

endmodule : secondary_irq_softint_monitor

// ===== irq_source_model.sv
// Far-side model: peripheral request sources and the core's vector fetch
module irq_source_model (
    // Clock and reset
    input  wire logic                             core_clk,
    input  wire logic                             rst,
    // Requests from the bench
    input  wire secondary_irq_pkg::card_src_type  cardCmd,
    input  wire secondary_irq_pkg::audio_src_type audioCmd,
    // Block side
    input  wire logic                             excReq,
    input  wire logic [7:0]                       excVector,
    output secondary_irq_pkg::card_src_type       cardSrc,
    output secondary_irq_pkg::audio_src_type      audioSrc,
    output logic      [7:0]                       takenVec
);
    logic excSeen_r;

    // Sources change just after an edge, as the real flops would
    always_ff @(posedge core_clk) begin
        cardSrc  <= cardCmd;
        audioSrc <= audioCmd;
    end

    // Core takes the vector only on a fresh request, never on a held one
    always_ff @(posedge core_clk) begin
        if (rst) begin
            excSeen_r <= 1'b0;
            takenVec  <= 8'h00;
        end else begin
            excSeen_r <= excReq;
            if (excReq && !excSeen_r) begin
                takenVec <= excVector;
            end
        end
    end
endmodule : irq_source_model

// ===== tb_top.sv
// Self-checking bench for the secondary interrupt block
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin err_total++; \
    $display("Error %0t: got %h expected %h", $time, got, exp); end end
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    // Lines owned by this block: 0..17, 47..50, 57..60
    localparam logic [63:0] OWN_LINES = 64'h1E07_8000_0003_FFFF;
    logic core_clk, rst, psel, penable, pwrite, pready, pslverr, excReq, irqOut;
    logic probeA, probeB, lastErr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdat, rndState;
    logic [3:0] pstrb;
    logic [2:0] coreMask;
    logic [7:0] excVector, takenVec;
    logic [63:0] extLines, secLines, expV;
    logic [5:0] selA, selB;
    secondary_irq_pkg::card_src_type  cardCmd, cardSrc;
    secondary_irq_pkg::audio_src_type audioCmd, audioSrc;
    int err_total, compares, swModel, cardModel, enModel;

    secondary_irq_softint_monitor u_secondary_irq_softint_monitor (.core_clk(core_clk),
        .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .audioSrc(audioSrc), .cardSrc(cardSrc), .extLines(extLines), .coreMask(coreMask),
        .excReq(excReq), .excVector(excVector), .secLines(secLines),
        .latency_probe_pin_a(probeA), .latency_probe_pin_b(probeB), .irqOut(irqOut));
    irq_source_model u_irq_source_model (.core_clk(core_clk), .rst(rst), .cardCmd(cardCmd),
        .audioCmd(audioCmd), .excReq(excReq), .excVector(excVector), .cardSrc(cardSrc),
        .audioSrc(audioSrc), .takenVec(takenVec));

    // Free-running clock, 40 ns period
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    function automatic logic [31:0] rnd();
        rndState = {rndState[30:0], rndState[31] ^ rndState[21] ^ rndState[1] ^ rndState[0]};
        return rndState;
    endfunction : rnd

    // Expected line vector built from the bench's own models
    function automatic logic [63:0] exp_lines();
        logic [63:0] v;
        logic [11:0] st;
        st = {cardCmd.txBufferBVacant, cardCmd.rxBufferBLoaded, cardCmd.txBufferAVacant,
              cardCmd.rxBufferALoaded, 8'(cardModel)} & 12'(enModel);
        v = extLines & ~OWN_LINES;
        v[17:0] = {audioCmd.rxBStatus, |audioCmd.uqErrRxA, audioCmd.midFlags,
                   |audioCmd.uqErrRxB, audioCmd.lowFlags};
        v[50:47] = 4'(swModel);
        v[60:57] = {|st[3:0], |st[7:4], |st[9:8], |st[11:10]};
        return v;
    endfunction : exp_lines

    task automatic finish_test();
        $display("Counts: %0d compares, %0d mismatches", compares, err_total);
        if (err_total == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : finish_test

    // One APB transfer; request held until pready is seen, then released
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       input logic [3:0] s);
        int n;
        n = 0;
        @(posedge core_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        pstrb   <= s;
        @(posedge core_clk);
        penable <= 1'b1;
        // Pready, read data and error are all taken at the same rising edge
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rdat    = prdata;
        lastErr = pslverr;
        if (n >= 16) begin
            err_total++;
            $display("Error %0t: no pready", $time);
            finish_test();
        end
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic settle(input int n);
        repeat (n) @(posedge core_clk);
        @(negedge core_clk);
    endtask : settle

    // Hang guard
    initial begin
        repeat (20000) @(posedge core_clk);
        err_total++;
        $display("Error %0t: run timed out", $time);
        finish_test();
    end

    // Main sequence
    initial begin
        {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
        {cardCmd, audioCmd, extLines, swModel, cardModel, enModel} = '0;
        {err_total, compares} = '0;
        coreMask = 3'h7;
        rndState = 32'h6837363B;
        rst = 1'b1;
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        apb(1'b0, secondary_irq_pkg::SW_CTRL_ADDR, 32'h0, 4'hF);
        `CHK(rdat, 32'h0000_0000)
        apb(1'b1, 12'h100, 32'hFFFF_FFFF, 4'hF);
        `CHK(lastErr, 1'b1)
        $display("Test reset done");
        // Raise each request in turn with byte writes, then drop each
        for (int i = 0; i < 8; i++) begin
            apb(1'b1, secondary_irq_pkg::SW_CTRL_ADDR, 32'h1 << ((i + 4) % 8), 4'h1);
            swModel = (i < 4) ? (swModel | (1 << i)) : (swModel & ~(1 << (i - 4)));
            settle(1);
            `CHK(secLines, exp_lines())
            apb(1'b0, secondary_irq_pkg::SW_CTRL_ADDR, 32'h0, 4'hF);
            `CHK(rdat[7:0], {4'(swModel), 4'(swModel)})
        end
        $display("Test software requests done");
        // Probe selectors, then a low-byte write that must spare them
        apb(1'b1, secondary_irq_pkg::SW_CTRL_ADDR, (32'd60 << 22) | (32'd47 << 16) | 32'h10, 4'hF);
        swModel = 1;
        settle(2);
        `CHK(probeA, 1'b1)
        apb(1'b1, secondary_irq_pkg::SW_CTRL_ADDR, 32'hFFFF_FF01, 4'h1);
        swModel = 0;
        settle(2);
        `CHK(probeA, 1'b0)
        apb(1'b0, secondary_irq_pkg::SW_CTRL_ADDR, 32'h0, 4'hF);
        `CHK(rdat[27:16], {6'd60, 6'd47})
        for (int i = 0; i < 6; i++) begin
            @(posedge core_clk);
            selA = 6'(rnd());
            selB = 6'(rnd());
            extLines <= {rnd(), rnd()};
            apb(1'b1, secondary_irq_pkg::SW_CTRL_ADDR, {4'h0, selB, selA, 16'h0}, 4'hF);
            settle(2);
            expV = exp_lines();
            `CHK({probeB, probeA}, {expV[selB], expV[selA]})
        end
        $display("Test probes done");
        // Both edges of each shifter and level signal, buffer levels, grouping, enables and clear
        apb(1'b1, secondary_irq_pkg::CARD_ENABLE_ADDR, 32'hFFF, 4'hF);
        enModel = 'hFFF;
        for (int i = 0; i < 8; i++) begin
            @(posedge core_clk);
            cardCmd[7 - i / 2] <= (i % 2 == 0);
            cardModel = cardModel | (1 << (2 * (i / 2) + (i % 2 == 0)));
            settle(3);
            `CHK(secLines, exp_lines())
        end
        apb(1'b1, secondary_irq_pkg::CARD_ENABLE_ADDR, 32'h00F, 4'hF);
        enModel = 'h00F;
        settle(1);
        `CHK(secLines, exp_lines())
        apb(1'b1, secondary_irq_pkg::CARD_CLEAR_ADDR, 32'h0F, 4'hF);
        cardModel = 'hF0;
        apb(1'b0, secondary_irq_pkg::CARD_STATUS_ADDR, 32'h0, 4'hF);
        `CHK(rdat[11:0], 12'h0F0)
        apb(1'b1, secondary_irq_pkg::CARD_CLEAR_ADDR, 32'hFFF, 4'hF);
        apb(1'b1, secondary_irq_pkg::CARD_ENABLE_ADDR, 32'hFFF, 4'hF);
        {cardModel, enModel} = {32'h0, 32'hFFF};
        for (int k = 0; k < 4; k++) begin
            @(posedge core_clk);
            cardCmd[3:0] <= 4'h1 << k;
            settle(2);
            `CHK(secLines, exp_lines())
            apb(1'b1, secondary_irq_pkg::CARD_CLEAR_ADDR, 32'hFFF, 4'hF);
            apb(1'b0, secondary_irq_pkg::CARD_STATUS_ADDR, 32'h0, 4'hF);
            `CHK(rdat[11:0], 12'h800 >> k)
        end
        $display("Test card sources done");
        // Random audio conditions and foreign lines
        for (int i = 0; i < 8; i++) begin
            @(posedge core_clk);
            audioCmd <= 22'(rnd());
            extLines <= {rnd(), rnd()};
            settle(2);
            `CHK(secLines, exp_lines())
        end
        $display("Test audio lines done");
        // Level against core mask, vector, event flag and interrupt
        apb(1'b1, secondary_irq_pkg::SW_CTRL_ADDR, 32'h10, 4'h1);
        apb(1'b1, secondary_irq_pkg::LEVEL_BASE_ADDR + 12'h014, 32'h3000_0000, 4'h8);
        coreMask <= 3'h3;
        settle(3);
        `CHK(excReq, 1'b0)
        @(posedge core_clk);
        coreMask <= 3'h2;
        settle(3);
        `CHK(excReq, 1'b1)
        `CHK(takenVec, secondary_irq_pkg::BASE_RESET + 8'd47)
        apb(1'b0, secondary_irq_pkg::EVT_STATUS_ADDR, 32'h0, 4'hF);
        `CHK({rdat[0], irqOut}, 2'b10)
        apb(1'b1, secondary_irq_pkg::EVT_MASK_ADDR, 32'h1, 4'h1);
        settle(1);
        `CHK(irqOut, 1'b1)
        apb(1'b1, secondary_irq_pkg::EVT_STATUS_ADDR, 32'h3, 4'h1);
        settle(1);
        `CHK(irqOut, 1'b0)
        apb(1'b1, secondary_irq_pkg::BASE_VEC_ADDR, 32'h10, 4'h1);
        settle(3);
        `CHK(excVector, 8'h10 + 8'd47)
        $display("Test exception done");
        finish_test();
    end
endmodule : tb_top
